/* File: rtl/fifo_pkg.sv */
/*
 * Shared constants and types for the dual-clock buffer: data and depth
 * widths, default threshold offsets, replay hold length and the enums
 * for timing mode and offset programming method.
 * Assumes nothing of its surroundings; imported whole by the design.
 */
`default_nettype none

package fifo_pkg;

    // ==================================================================
    // widths
    // ==================================================================
    localparam int DATA_W = 18;                       // word width
    localparam int ADDR_W_SMALL = 13;                 // 8,192-word build
    localparam int ADDR_W_LARGE = 14;                 // 16,384-word build
    localparam int OFFSET_W = ADDR_W_LARGE;           // threshold register width

    // ==================================================================
    // reset values
    // ==================================================================
    localparam logic [OFFSET_W-1:0] OFFSET_DEFAULT_PAR = 14'h007f; // 127, parallel
    localparam logic [OFFSET_W-1:0] OFFSET_DEFAULT_SER = 14'h03ff; // 1,023, serial
    localparam logic [OFFSET_W-1:0] OFFSET_RESET = 14'h0000;       // shadow copy at power-up

    // ==================================================================
    // timing counts, in read clock cycles
    // ==================================================================
    localparam logic [1:0] REPLAY_HOLD = 2'h2;        // empty forced after replay

    // ==================================================================
    // modes
    // ==================================================================
    typedef enum logic {MODE_STANDARD, MODE_EARLY} mode_e;
    typedef enum logic {LOAD_PARALLEL, LOAD_SERIAL} load_e;

endpackage

`default_nettype wire

/* File: rtl/sync_2ff.sv */
/*
 * Two flip-flop synchroniser for gray pointers and toggle levels.
 * Assumes each bit of the input changes at most one bit at a time
 * (gray code or toggle), so a word arrives whole or not at all.
 */
`timescale 1ns/1ns
`default_nettype none

module sync_2ff #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    // ==================================================================
    // capture stages
    // ==================================================================
    logic [WIDTH-1:0] meta; // first stage, read only by the second
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    // clear lets the owning domain forget stale values during its resets
    always_comb begin
        next_meta = clear ? '0 : d;
        next_q = clear ? '0 : meta;
    end

    // plain registering only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end

endmodule

`default_nettype wire

/* File: rtl/dual_clock_fifo_flags.sv */
/*
 * Deep dual-clock first-in-first-out buffer with standard and early
 * output timing, empty/full/half flags and programmable almost flags.
 * Assumes control pins are synchronous to the clock that samples them;
 * reset pins are held for several edges of both clocks.
 */
// The strobe-based ports and the offset load order were chosen for this implementation.
// Functional notes
// - 8,192 or 16,384 words of 18 bits
// - write strobe stores data each write edge
// - read strobe reads next word each read edge
// - output enable gates read data drive
// - clocks independent, any rate, no relation
// - standard mode: word shown only after read
// - early mode: first word shown after three edges
// - early mode: later words need read strobe
// - mode pin level during full reset sets mode
// - early mode outputs chain to next inputs
// - shared flag pins change meaning with mode
// - almost thresholds independent, any fill level
// - full reset picks 127 parallel or 1,023 serial
// - serial load: one bit per enabled write edge
// - parallel load: offsets from write data bus
// - read strobe with load select reads offsets
// - full reset clears pointers, latches configuration
// - soft reset clears pointers, keeps configuration
// - replay request rewinds read pointer to start
// - almost full when count exceeds capacity minus m
// - almost empty when count below n
// - half flag shows count against half capacity
// - replay forces empty, leaves the write side alone
`timescale 1ns/1ns
`default_nettype none

module dual_clock_fifo_flags
    import fifo_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_LARGE // or ADDR_W_SMALL
) (
    input wire logic MCLK, // write clock
    input wire logic READ_CLK, // read clock, unrelated to MCLK
    input wire logic RST_N, // power-up reset
    input wire logic FULL_RESET_N,
    input wire logic SOFT_RESET_N,
    input wire logic WRITE_STROBE_N,
    input wire logic [DATA_W-1:0] WRITE_DATA_BUS,
    input wire logic OFFSET_LOAD_SELECT_N,
    input wire logic SERIAL_LOAD_ENABLE_N,
    input wire logic MODE_SELECT_SERIAL_IN,
    input wire logic READ_STROBE_N,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic REPLAY_REQUEST_N,
    output logic [DATA_W-1:0] READ_DATA_BUS,
    output logic READ_DATA_OE,
    output logic EMPTY_INDICATOR_N, // data_valid_out_n in early mode
    output logic FULL_INDICATOR_N, // input_ready_n in early mode
    output logic HALF_LEVEL_FLAG_N,
    output logic ALMOST_EMPTY_FLAG_N,
    output logic ALMOST_FULL_FLAG_N
);

    // ==================================================================
    // sizes and helpers
    // ==================================================================
    localparam int PTR_W = ADDR_W + 1; // extra wrap bit
    localparam int DEPTH = 1 << ADDR_W;
    localparam logic [PTR_W-1:0] CAPACITY = PTR_W'(DEPTH);
    localparam logic [PTR_W-1:0] HALF = PTR_W'(DEPTH / 2);

    function automatic logic [PTR_W-1:0] to_gray(input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PTR_W-1:0] from_gray(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b = g;
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // ==================================================================
    // storage
    // ==================================================================
    logic [DATA_W-1:0] mem [0:DEPTH-1];
    logic mem_we;

    // ==================================================================
    // write domain state
    // ==================================================================
    logic [PTR_W-1:0] wr_ptr, next_wr_ptr;
    logic [OFFSET_W-1:0] empty_off, next_empty_off; // n, from empty side
    logic [OFFSET_W-1:0] full_off, next_full_off; // m, from full side
    logic par_sel, next_par_sel; // which offset the next parallel word hits
    mode_e mode_w, next_mode_w;
    load_e load_w, next_load_w;
    logic [PTR_W-1:0] rd_gray_w; // read pointer seen by write side
    logic [PTR_W-1:0] rd_ptr_w;
    logic wr_full; // full before this edge
    logic [PTR_W-1:0] wr_count; // words after this edge
    logic next_full_pin, next_half_pin, next_afull_pin;
    logic w_reset;

    // offset handover to the read side
    logic [OFFSET_W-1:0] sh_empty, next_sh_empty, sh_full, next_sh_full;
    logic sh_req, next_sh_req;
    logic ack_w; // returned acknowledge toggle

    assign w_reset = !FULL_RESET_N || !SOFT_RESET_N;
    assign rd_ptr_w = from_gray(rd_gray_w);
    assign wr_full = (wr_ptr - rd_ptr_w) == CAPACITY;

    // write side next state: resets, offset loading, data writes, flags
    always_comb begin
        next_wr_ptr = wr_ptr;
        next_empty_off = empty_off;
        next_full_off = full_off;
        next_par_sel = par_sel;
        next_mode_w = mode_w;
        next_load_w = load_w;
        mem_we = 1'b0;
        if (!FULL_RESET_N) begin
            // configuration caught while the reset is held
            next_mode_w = MODE_SELECT_SERIAL_IN ? MODE_EARLY : MODE_STANDARD;
            next_load_w = OFFSET_LOAD_SELECT_N ? LOAD_SERIAL : LOAD_PARALLEL;
            next_empty_off = OFFSET_LOAD_SELECT_N ? OFFSET_DEFAULT_SER : OFFSET_DEFAULT_PAR;
            next_full_off = OFFSET_LOAD_SELECT_N ? OFFSET_DEFAULT_SER : OFFSET_DEFAULT_PAR;
            next_wr_ptr = '0;
            next_par_sel = 1'b0;
        end else if (!SOFT_RESET_N) begin
            next_wr_ptr = '0; // configuration kept
            next_par_sel = 1'b0;
        end else if (!OFFSET_LOAD_SELECT_N) begin
            // load select steals the write strobe from the data path
            if (load_w == LOAD_PARALLEL && !WRITE_STROBE_N) begin
                if (!par_sel) begin
                    next_empty_off = WRITE_DATA_BUS[OFFSET_W-1:0];
                end else begin
                    next_full_off = WRITE_DATA_BUS[OFFSET_W-1:0];
                end
                next_par_sel = !par_sel;
            end else if (load_w == LOAD_SERIAL && !SERIAL_LOAD_ENABLE_N) begin
                // lsb first, empty offset first, then full
                {next_full_off, next_empty_off} =
                    {MODE_SELECT_SERIAL_IN, full_off, empty_off[OFFSET_W-1:1]};
            end
        end else if (!WRITE_STROBE_N && !wr_full) begin
            mem_we = 1'b1;
            next_wr_ptr = wr_ptr + 1'b1; // full writes dropped
        end
        wr_count = w_reset ? '0 : next_wr_ptr - rd_ptr_w;
        // full sense flips with mode on the shared pin
        next_full_pin = (next_mode_w == MODE_EARLY) ? (wr_count == CAPACITY)
                                                    : (wr_count != CAPACITY);
        next_half_pin = !(wr_count > HALF);
        next_afull_pin = !(wr_count > CAPACITY - PTR_W'(next_full_off));
    end

    // write side registers
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_ptr <= '0;
            empty_off <= OFFSET_DEFAULT_PAR;
            full_off <= OFFSET_DEFAULT_PAR;
            par_sel <= 1'b0;
            mode_w <= MODE_STANDARD;
            load_w <= LOAD_PARALLEL;
            FULL_INDICATOR_N <= 1'b1;
            HALF_LEVEL_FLAG_N <= 1'b1;
            ALMOST_FULL_FLAG_N <= 1'b1;
        end else begin
            wr_ptr <= next_wr_ptr;
            empty_off <= next_empty_off;
            full_off <= next_full_off;
            par_sel <= next_par_sel;
            mode_w <= next_mode_w;
            load_w <= next_load_w;
            FULL_INDICATOR_N <= next_full_pin;
            HALF_LEVEL_FLAG_N <= next_half_pin;
            ALMOST_FULL_FLAG_N <= next_afull_pin;
        end
    end

    // memory write port, no reset needed on data
    always_ff @(posedge MCLK) begin
        if (mem_we) begin
            mem[wr_ptr[ADDR_W-1:0]] <= WRITE_DATA_BUS;
        end
    end

    // shadow copy only changes while no handover is in flight
    always_comb begin
        next_sh_empty = sh_empty;
        next_sh_full = sh_full;
        next_sh_req = sh_req;
        if (ack_w == sh_req && {sh_empty, sh_full} != {empty_off, full_off}) begin
            next_sh_empty = empty_off;
            next_sh_full = full_off;
            next_sh_req = !sh_req;
        end
    end

    // handover registers
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            sh_empty <= OFFSET_RESET;
            sh_full <= OFFSET_RESET;
            sh_req <= 1'b0;
        end else begin
            sh_empty <= next_sh_empty;
            sh_full <= next_sh_full;
            sh_req <= next_sh_req;
        end
    end

    // ==================================================================
    // domain crossings
    // ==================================================================
    logic [PTR_W-1:0] wr_gray, rd_gray, wr_gray_r;
    logic sh_req_r, ack_r, r_reset;

    assign wr_gray = to_gray(wr_ptr);

    // gray pointers, cleared during the receiving side's reset
    sync_2ff #(.WIDTH(PTR_W)) rd_to_wr (
        .clk(MCLK), .rst_n(RST_N), .clear(w_reset), .d(rd_gray), .q(rd_gray_w)
    );
    sync_2ff #(.WIDTH(PTR_W)) wr_to_rd (
        .clk(READ_CLK), .rst_n(RST_N), .clear(r_reset), .d(wr_gray), .q(wr_gray_r)
    );
    // request and acknowledge toggles for the offset handover
    sync_2ff #(.WIDTH(1)) req_to_rd (
        .clk(READ_CLK), .rst_n(RST_N), .clear(1'b0), .d(sh_req), .q(sh_req_r)
    );
    sync_2ff #(.WIDTH(1)) ack_to_wr (
        .clk(MCLK), .rst_n(RST_N), .clear(1'b0), .d(ack_r), .q(ack_w)
    );

    // ==================================================================
    // read domain state
    // ==================================================================
    logic [PTR_W-1:0] rd_ptr, next_rd_ptr;
    logic [PTR_W-1:0] wr_ptr_r; // write pointer seen by read side
    logic valid, next_valid; // output register holds an unread word
    logic [DATA_W-1:0] next_dout;
    logic rd_sel, next_rd_sel; // which offset the next readback shows
    mode_e mode_r, next_mode_r;
    logic [1:0] hold, next_hold;
    logic [OFFSET_W-1:0] empty_off_r, full_off_r, next_empty_off_r, next_full_off_r;
    logic next_ack_r;
    logic rd_empty;
    logic [PTR_W-1:0] rd_count;
    logic next_empty_pin, next_aempty_pin;

    assign r_reset = !FULL_RESET_N || !SOFT_RESET_N;
    assign wr_ptr_r = from_gray(wr_gray_r);
    assign rd_empty = (wr_ptr_r == rd_ptr);
    assign rd_gray = to_gray(rd_ptr);

    // read side next state: resets, replay, offset readback, data reads
    always_comb begin
        next_rd_ptr = rd_ptr;
        next_valid = valid;
        next_dout = READ_DATA_BUS;
        next_rd_sel = rd_sel;
        next_mode_r = mode_r;
        next_hold = hold;
        if (!FULL_RESET_N) begin
            next_mode_r = MODE_SELECT_SERIAL_IN ? MODE_EARLY : MODE_STANDARD;
            next_rd_ptr = '0;
            next_valid = 1'b0;
            next_dout = '0;
            next_rd_sel = 1'b0;
            next_hold = '0;
        end else if (!SOFT_RESET_N) begin
            next_rd_ptr = '0;
            next_valid = 1'b0;
            next_dout = '0;
            next_rd_sel = 1'b0;
            next_hold = '0;
        end else if (!REPLAY_REQUEST_N) begin
            next_rd_ptr = '0; // write side untouched
            next_valid = 1'b0;
            next_hold = REPLAY_HOLD;
        end else if (hold != 2'h0) begin
            next_hold = hold - 2'h1; // reads wait out the replay window
        end else if (!READ_STROBE_N && !OFFSET_LOAD_SELECT_N) begin
            // readback works under either load method
            next_dout = DATA_W'(rd_sel ? full_off_r : empty_off_r);
            next_rd_sel = !rd_sel;
        end else if (mode_r == MODE_STANDARD) begin
            if (!READ_STROBE_N && !rd_empty) begin
                next_dout = mem[rd_ptr[ADDR_W-1:0]];
                next_rd_ptr = rd_ptr + 1'b1; // empty reads dropped
            end
        end else begin
            // early mode: refill the output word when it is free or taken
            if (!valid || !READ_STROBE_N) begin
                if (!rd_empty) begin
                    next_dout = mem[rd_ptr[ADDR_W-1:0]];
                    next_rd_ptr = rd_ptr + 1'b1;
                    next_valid = 1'b1;
                end else begin
                    next_valid = 1'b0;
                end
            end
        end
        rd_count = r_reset ? '0 : wr_ptr_r - next_rd_ptr;
        // empty sense flips with mode on the shared pin
        if (next_mode_r == MODE_EARLY) begin
            next_empty_pin = !next_valid;
        end else begin
            next_empty_pin = !(rd_count == '0 || next_hold != 2'h0);
        end
        next_aempty_pin = !(rd_count < PTR_W'(empty_off_r));
    end

    // read side registers
    always_ff @(posedge READ_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_ptr <= '0;
            valid <= 1'b0;
            READ_DATA_BUS <= '0;
            rd_sel <= 1'b0;
            mode_r <= MODE_STANDARD;
            hold <= '0;
            EMPTY_INDICATOR_N <= 1'b0;
            ALMOST_EMPTY_FLAG_N <= 1'b0;
            READ_DATA_OE <= 1'b0;
        end else begin
            rd_ptr <= next_rd_ptr;
            valid <= next_valid;
            READ_DATA_BUS <= next_dout;
            rd_sel <= next_rd_sel;
            mode_r <= next_mode_r;
            hold <= next_hold;
            EMPTY_INDICATOR_N <= next_empty_pin;
            ALMOST_EMPTY_FLAG_N <= next_aempty_pin;
            READ_DATA_OE <= !OUTPUT_ENABLE_N;
        end
    end

    // offset copy: shadow is stable while request and acknowledge differ
    always_comb begin
        next_empty_off_r = empty_off_r;
        next_full_off_r = full_off_r;
        next_ack_r = ack_r;
        if (sh_req_r != ack_r) begin
            next_empty_off_r = sh_empty;
            next_full_off_r = sh_full;
            next_ack_r = sh_req_r;
        end
    end

    // read side offset copy registers
    always_ff @(posedge READ_CLK or negedge RST_N) begin
        if (!RST_N) begin
            empty_off_r <= OFFSET_RESET;
            full_off_r <= OFFSET_RESET;
            ack_r <= 1'b0;
        end else begin
            empty_off_r <= next_empty_off_r;
            full_off_r <= next_full_off_r;
            ack_r <= next_ack_r;
        end
    end

    // ==================================================================
    // checks
    // ==================================================================
    logic w_run, r_run;
    assign w_run = FULL_RESET_N && SOFT_RESET_N;
    assign r_run = w_run && REPLAY_REQUEST_N && hold == 2'h0;

    full_drop_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        w_run && OFFSET_LOAD_SELECT_N && !WRITE_STROBE_N && wr_full |=> $stable(wr_ptr))
        else $error("write accepted while full");

    write_step_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        w_run && OFFSET_LOAD_SELECT_N && !WRITE_STROBE_N && !wr_full
        |=> wr_ptr == $past(wr_ptr) + 1'b1)
        else $error("write did not advance pointer");

    default_offset_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        !FULL_RESET_N |=> (empty_off == full_off) && (empty_off ==
            ($past(OFFSET_LOAD_SELECT_N) ? OFFSET_DEFAULT_SER : OFFSET_DEFAULT_PAR)))
        else $error("wrong default offset");

    serial_shift_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        w_run && !OFFSET_LOAD_SELECT_N && !SERIAL_LOAD_ENABLE_N && load_w == LOAD_SERIAL
        |=> full_off[OFFSET_W-1] == $past(MODE_SELECT_SERIAL_IN)
            && empty_off[OFFSET_W-1] == $past(full_off[0]))
        else $error("serial bit not shifted in");

    soft_keep_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        FULL_RESET_N && !SOFT_RESET_N
        |=> wr_ptr == '0 && $stable(mode_w) && $stable(empty_off) && $stable(full_off))
        else $error("soft reset disturbed configuration");

    replay_rewind_a: assert property (@(posedge READ_CLK) disable iff (!RST_N)
        w_run && !REPLAY_REQUEST_N
        |=> rd_ptr == '0 && (mode_r == MODE_EARLY ? EMPTY_INDICATOR_N : !EMPTY_INDICATOR_N))
        else $error("replay did not rewind and flag empty");

    empty_drop_a: assert property (@(posedge READ_CLK) disable iff (!RST_N)
        r_run && OFFSET_LOAD_SELECT_N && !READ_STROBE_N && rd_empty
        && mode_r == MODE_STANDARD |=> $stable(rd_ptr))
        else $error("read accepted while empty");

    early_fall_a: assert property (@(posedge READ_CLK) disable iff (!RST_N)
        r_run && mode_r == MODE_EARLY && !valid && !rd_empty
        && (READ_STROBE_N || OFFSET_LOAD_SELECT_N)
        |=> valid && !EMPTY_INDICATOR_N && READ_DATA_BUS == $past(mem[rd_ptr[ADDR_W-1:0]]))
        else $error("first word did not fall through");

    oe_follow_a: assert property (@(posedge READ_CLK) disable iff (!RST_N)
        1'b1 |=> READ_DATA_OE == !$past(OUTPUT_ENABLE_N))
        else $error("output enable not followed");

    offset_read_a: assert property (@(posedge READ_CLK) disable iff (!RST_N)
        r_run && !READ_STROBE_N && !OFFSET_LOAD_SELECT_N
        |=> READ_DATA_BUS[OFFSET_W-1:0] == $past(rd_sel ? full_off_r : empty_off_r))
        else $error("offset readback wrong");

    write_full_c: cover property (@(posedge MCLK) disable iff (!RST_N)
        w_run && !WRITE_STROBE_N && wr_full);
    early_first_c: cover property (@(posedge READ_CLK) disable iff (!RST_N)
        mode_r == MODE_EARLY && !valid ##1 valid);
    replay_c: cover property (@(posedge READ_CLK) disable iff (!RST_N)
        !REPLAY_REQUEST_N && w_run && rd_ptr != '0);

endmodule

`default_nettype wire

/* File: sim/word_writer.sv */
/* upstream writer model: one word per request on the write port.
   assumes the bench pulses go for one write clock cycle. */
`timescale 1ns/1ns
`default_nettype none
module word_writer (
    input wire logic clk,
    input wire logic go,
    input wire logic [17:0] word,
    output logic strobe_n,
    output logic [17:0] data
);
    // ==========
    // drive
    // ==========
    initial begin
        strobe_n = 1'b1;
        data = 18'h00000;
    end
    // strobe and data change together after the edge
    always @(posedge clk) begin
        if (go) begin
            strobe_n <= 1'b0;
            data <= word;
        end else begin
            // idle bus flips so a stale word can never pass for fresh
            strobe_n <= 1'b1;
            data <= ~data;
        end
    end
endmodule
`default_nettype wire

/* File: sim/dual_clock_fifo_flags_test.sv */
/* bench for the dual-clock buffer: pin-level write, read, offset and
   reset sequences. assumes the design package is compiled first. */
`timescale 1ns/1ns
`default_nettype none
module dual_clock_fifo_flags_test;
    import fifo_pkg::*;
    logic MCLK = 0, READ_CLK = 0, RST_N = 0, FULL_RESET_N = 1, SOFT_RESET_N = 1;
    logic OFFSET_LOAD_SELECT_N = 1, SERIAL_LOAD_ENABLE_N = 1, MODE_SELECT_SERIAL_IN = 0;
    logic READ_STROBE_N = 1, OUTPUT_ENABLE_N = 1, REPLAY_REQUEST_N = 1, go = 0;
    logic WRITE_STROBE_N, READ_DATA_OE, EMPTY_INDICATOR_N, FULL_INDICATOR_N;
    logic HALF_LEVEL_FLAG_N, ALMOST_EMPTY_FLAG_N, ALMOST_FULL_FLAG_N;
    logic [17:0] word = 0, WRITE_DATA_BUS, READ_DATA_BUS;
    logic [27:0] ser = {14'h0009, 14'h0005}; // serial offsets, m above n, sent lsb first
    int errors = 0, total_checks = 0, cycles = 0;
    always #2 MCLK = ~MCLK;
    always #3 READ_CLK = ~READ_CLK; // read side slower, unrelated phase
    word_writer writer (.clk(MCLK), .go(go), .word(word), .strobe_n(WRITE_STROBE_N),
        .data(WRITE_DATA_BUS));
    dual_clock_fifo_flags uut (.MCLK(MCLK), .READ_CLK(READ_CLK), .RST_N(RST_N),
        .FULL_RESET_N(FULL_RESET_N), .SOFT_RESET_N(SOFT_RESET_N),
        .WRITE_STROBE_N(WRITE_STROBE_N), .WRITE_DATA_BUS(WRITE_DATA_BUS),
        .OFFSET_LOAD_SELECT_N(OFFSET_LOAD_SELECT_N), .SERIAL_LOAD_ENABLE_N(SERIAL_LOAD_ENABLE_N),
        .MODE_SELECT_SERIAL_IN(MODE_SELECT_SERIAL_IN), .READ_STROBE_N(READ_STROBE_N),
        .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .REPLAY_REQUEST_N(REPLAY_REQUEST_N),
        .READ_DATA_BUS(READ_DATA_BUS), .READ_DATA_OE(READ_DATA_OE),
        .EMPTY_INDICATOR_N(EMPTY_INDICATOR_N), .FULL_INDICATOR_N(FULL_INDICATOR_N),
        .HALF_LEVEL_FLAG_N(HALF_LEVEL_FLAG_N), .ALMOST_EMPTY_FLAG_N(ALMOST_EMPTY_FLAG_N),
        .ALMOST_FULL_FLAG_N(ALMOST_FULL_FLAG_N));
    // ==========
    // tasks
    // ==========
    task automatic print_verdict();
        if (errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rwait(input int n);
        repeat (n) @(posedge READ_CLK);
    endtask
    // one write via the upstream model
    task automatic wr(input logic [17:0] d);
        @(posedge MCLK) go <= 1'b1;
        word <= d;
        @(posedge MCLK) go <= 1'b0;
        repeat (2) @(posedge MCLK);
    endtask
    // one strobed read; data checked in the cycle after the read edge
    task automatic rd(input logic [17:0] exp);
        @(posedge READ_CLK) READ_STROBE_N <= 1'b0;
        @(posedge READ_CLK) READ_STROBE_N <= 1'b1;
        @(negedge READ_CLK) chk(READ_DATA_BUS, exp);
    endtask
    // full reset held across both clocks, pins steady throughout
    task automatic frst(input logic early, input logic ld_n);
        @(posedge READ_CLK) FULL_RESET_N <= 1'b0;
        MODE_SELECT_SERIAL_IN <= early;
        OFFSET_LOAD_SELECT_N <= ld_n;
        rwait(6);
        FULL_RESET_N <= 1'b1;
        rwait(6);
        OFFSET_LOAD_SELECT_N <= 1'b1;
        MODE_SELECT_SERIAL_IN <= 1'b0;
    endtask
    // hang guard
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge MCLK);
        RST_N <= 1'b1;
        frst(1'b0, 1'b1);
        @(negedge READ_CLK);
        chk({17'h0, EMPTY_INDICATOR_N}, 18'h0);
        chk({17'h0, FULL_INDICATOR_N}, 18'h1);
        chk({17'h0, ALMOST_EMPTY_FLAG_N}, 18'h0);
        chk({17'h0, ALMOST_FULL_FLAG_N}, 18'h1);
        chk({17'h0, HALF_LEVEL_FLAG_N}, 18'h1);
        @(posedge READ_CLK) OFFSET_LOAD_SELECT_N <= 1'b0;
        rd(18'h003ff);
        rd(18'h003ff);
        // serial load n=5, m=9 while load select stays low
        for (int i = 0; i < 28; i++) begin
            @(posedge MCLK) SERIAL_LOAD_ENABLE_N <= 1'b0;
            MODE_SELECT_SERIAL_IN <= ser[i];
        end
        @(posedge MCLK) SERIAL_LOAD_ENABLE_N <= 1'b1;
        rwait(20); // offset copy crosses to the read side by handshake
        rd(18'h00005);
        rd(18'h00009);
        frst(1'b0, 1'b0);
        @(posedge READ_CLK) OFFSET_LOAD_SELECT_N <= 1'b0;
        rd(18'h0007f);
        rd(18'h0007f);
        // parallel load n=2, m=9 through the write port
        @(posedge MCLK) OFFSET_LOAD_SELECT_N <= 1'b0;
        wr(18'h00002);
        wr(18'h00009);
        rwait(16); // let the read-side offset copy catch up
        rd(18'h00002);
        rd(18'h00009);
        @(posedge MCLK) OFFSET_LOAD_SELECT_N <= 1'b1;
        wr(18'h11111);
        wr(18'h22222);
        wr(18'h33333);
        rwait(8);
        @(negedge READ_CLK);
        chk(READ_DATA_BUS, 18'h00009);
        chk({17'h0, EMPTY_INDICATOR_N}, 18'h1);
        chk({17'h0, ALMOST_EMPTY_FLAG_N}, 18'h1);
        rd(18'h11111);
        rd(18'h22222);
        rd(18'h33333);
        rwait(2);
        @(negedge READ_CLK);
        chk({17'h0, EMPTY_INDICATOR_N}, 18'h0);
        @(posedge READ_CLK) REPLAY_REQUEST_N <= 1'b0;
        @(posedge READ_CLK) REPLAY_REQUEST_N <= 1'b1;
        rwait(4);
        rd(18'h11111);
        @(posedge READ_CLK) OUTPUT_ENABLE_N <= 1'b0;
        rwait(2);
        @(negedge READ_CLK);
        chk({17'h0, READ_DATA_OE}, 18'h1);
        // soft reset: pointers cleared, offsets kept
        @(posedge READ_CLK) SOFT_RESET_N <= 1'b0;
        rwait(6);
        SOFT_RESET_N <= 1'b1;
        rwait(4);
        @(negedge READ_CLK);
        chk({17'h0, EMPTY_INDICATOR_N}, 18'h0);
        chk(READ_DATA_BUS, 18'h00000);
        @(posedge READ_CLK) OFFSET_LOAD_SELECT_N <= 1'b0;
        rd(18'h00002);
        frst(1'b1, 1'b1);
        wr(18'h2a5a5);
        wr(18'h15a5a);
        rwait(6);
        @(negedge READ_CLK);
        chk({17'h0, EMPTY_INDICATOR_N}, 18'h0);
        chk({17'h0, FULL_INDICATOR_N}, 18'h0);
        chk(READ_DATA_BUS, 18'h2a5a5);
        rd(18'h15a5a);
        print_verdict();
    end
endmodule
`default_nettype wire
